// ==== verilog/wdspc_pkg.sv ====
// Package for the watchdog and soft power control block.
// Assumes a 50 MHz sys_clk and a byte-wide register port.
package wdspc_pkg;
  localparam logic [7:0] WDSPC_ADDR_UNITS = 8'hf1;
  localparam logic [7:0] WDSPC_ADDR_VALUE = 8'hf2;
  localparam logic [7:0] WDSPC_ADDR_CFG = 8'hf3;
  localparam logic [7:0] WDSPC_ADDR_CTRL = 8'hf4;
  localparam logic [7:0] WDSPC_ADDR_DELAY = 8'hb8;
  localparam logic [7:0] WDSPC_RESET_BYTE = 8'h00;
  localparam logic [7:0] WDSPC_DELAY_DEFAULT = 8'h05;
  localparam int WDSPC_UNITS_BIT = 7;
  localparam int WDSPC_CFG_GAME = 0;
  localparam int WDSPC_CFG_KBD = 1;
  localparam int WDSPC_CFG_MOUSE = 2;
  localparam int WDSPC_CFG_LED = 3;
  localparam int WDSPC_CFG_IRQ_LO = 4;
  localparam int WDSPC_CTL_STATUS = 0;
  localparam int WDSPC_CTL_LED = 1;
  localparam int WDSPC_CTL_FORCE = 2;
  localparam int WDSPC_CTL_KBCEN = 3;
  localparam int WDSPC_CTL_ABORT = 5;
  localparam int WDSPC_CTL_RESTART = 6;
  localparam int WDSPC_CTL_POFF = 7;
  localparam logic [3:0] WDSPC_IRQ_OFF = 4'h0;
  localparam logic [3:0] WDSPC_IRQ_BAD = 4'h2;
  localparam int WDSPC_CLK_HZ = 50000000;
  localparam int WDSPC_HALF_SEC_MS = 500;
  localparam int WDSPC_DELAY_STEP_MS = 100;
  localparam int WDSPC_SEC_PER_MIN = 60;
  localparam int WDSPC_CYC_SEC = WDSPC_CLK_HZ;
  localparam int WDSPC_CYC_HALF = WDSPC_CLK_HZ / 1000 * WDSPC_HALF_SEC_MS;
  localparam int WDSPC_CYC_STEP = WDSPC_CLK_HZ / 1000 * WDSPC_DELAY_STEP_MS;
  localparam logic [5:0] WDSPC_MIN_LAST = 6'(WDSPC_SEC_PER_MIN - 1);
  typedef enum {WDSPC_PB_IDLE, WDSPC_PB_RUN, WDSPC_PB_OFF} wdspc_pb_t;
endpackage

// ==== verilog/wdspc_sync.sv ====
// Three-stage synchroniser for pin inputs with agreement on stages two and three.
// Assumes one sys_clk domain.
`timescale 1ns/100ps
module wdspc_sync
  import wdspc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic pin_in,
  output logic level_out
);
  typedef struct packed {
    logic [2:0] stage;
    logic level;
  } wdspc_sync_t;
  wdspc_sync_t st_q;
  wdspc_sync_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.stage = {st_q.stage[1:0], pin_in};
    if (st_q.stage[1] == st_q.stage[2]) begin
      st_d.level = st_q.stage[2];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign level_out = st_q.level;
endmodule // wdspc_sync

// ==== verilog/wdspc_top.sv ====
// Watchdog timer with power LED blink and power-button shutdown delay control.
// Assumes a single 50 MHz sys_clk, synchronous active-low reset, and
// event pins from outside logic that must be synchronised, except game_port_access, which is used unsynchronised.
// Functional notes
// - Units bit 7 selects seconds when one, minutes when zero.
// - Timeout value zero disables the watchdog.
// - Value N from 1 to 255 times out after N units.
// - Game port access re-arms when its enable is set.
// - Keyboard interrupt re-arms when its enable is set.
// - Mouse interrupt re-arms when its enable is set.
// - LED blinks at 1 Hz while status set and enabled.
// - Four-bit field maps interrupt; zero off, two invalid.
// - Status flag is set on timeout, readable and writable.
// - Control LED bit blinks power LED at 1 Hz.
// - Writing force bit makes a timeout; the bit self-clears.
// - Rising edge of kbc line forces timeout when enabled.
// - Only rising edge of kbc line counts, ORed with software force.
// - Abort stops shutdown delay; read shows one when stopped.
// - Restart reloads shutdown delay; repeatable indefinitely.
// - Writing power-off bit forces power down; self-clears.
// - Activate bit clear disables configuration bits 0 and 1.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
module wdspc_top
  import wdspc_pkg::*;
#(
  parameter int CYC_SEC = WDSPC_CYC_SEC,
  parameter int CYC_HALF = WDSPC_CYC_HALF,
  parameter int CYC_STEP = WDSPC_CYC_STEP
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic standby_por_n,
  input wire logic dev_activate,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic game_port_access,
  input wire logic kbd_irq_pin,
  input wire logic mouse_irq_pin,
  input wire logic kbc_force_line,
  input wire logic power_button,
  output logic [15:0] isa_irq,
  output logic power_led,
  output logic power_down
);
  typedef struct packed {
    logic [7:0] units;
    logic [7:0] value;
    logic [7:0] cfg;
    logic status;
    logic led_en;
    logic kbc_en;
    logic [7:0] delay;
    logic [7:0] count;
    logic [31:0] pre;
    logic [5:0] sec_in_min;
    logic [31:0] blink_cnt;
    logic blink;
    logic kbd_prev;
    logic mouse_prev;
    logic kbc_prev;
    logic btn_prev;
    wdspc_pb_t pb;
    logic [7:0] step_left;
    logic [31:0] step_cnt;
    logic poff;
    logic [7:0] rdata;
  } wdspc_state_t;
  wdspc_state_t st_q;
  wdspc_state_t st_d;
  logic kbd_s;
  logic mouse_s;
  logic kbc_s;
  logic btn_s;
  logic wr_ctrl;
  logic rearm;
  logic force_ev;
  logic unit_tick;
  logic led_active;

  wdspc_sync u_sync_kbd (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .pin_in(kbd_irq_pin), .level_out(kbd_s));
  wdspc_sync u_sync_mouse (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .pin_in(mouse_irq_pin), .level_out(mouse_s));
  wdspc_sync u_sync_kbc (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .pin_in(kbc_force_line), .level_out(kbc_s));
  wdspc_sync u_sync_btn (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .pin_in(power_button), .level_out(btn_s));

  assign wr_ctrl = reg_wr && (reg_addr == WDSPC_ADDR_CTRL);

  always_comb begin
    rearm = 1'b0;
    if (dev_activate && st_q.cfg[WDSPC_CFG_GAME] && game_port_access) begin
      rearm = 1'b1;
    end
    if (dev_activate && st_q.cfg[WDSPC_CFG_KBD] && kbd_s && !st_q.kbd_prev) begin
      rearm = 1'b1;
    end
    if (st_q.cfg[WDSPC_CFG_MOUSE] && mouse_s && !st_q.mouse_prev) begin
      rearm = 1'b1;
    end
  end

  assign force_ev = (wr_ctrl && reg_wdata[WDSPC_CTL_FORCE]) ||
    (st_q.kbc_en && kbc_s && !st_q.kbc_prev);

  assign unit_tick = (st_q.pre == 32'(CYC_SEC - 1)) &&
    (st_q.units[WDSPC_UNITS_BIT] || (st_q.sec_in_min == WDSPC_MIN_LAST));

  assign led_active = st_q.led_en || (st_q.cfg[WDSPC_CFG_LED] && st_q.status);

  always_comb begin
    st_d = st_q;
    st_d.kbd_prev = kbd_s;
    st_d.mouse_prev = mouse_s;
    st_d.kbc_prev = kbc_s;
    st_d.btn_prev = btn_s;
    st_d.poff = 1'b0;
    st_d.rdata = WDSPC_RESET_BYTE;
    if (reg_rd) begin
      case (reg_addr)
        WDSPC_ADDR_UNITS: st_d.rdata = st_q.units;
        WDSPC_ADDR_VALUE: st_d.rdata = st_q.value;
        WDSPC_ADDR_CFG: st_d.rdata = st_q.cfg;
        WDSPC_ADDR_CTRL: st_d.rdata = {2'b00, st_q.pb != WDSPC_PB_RUN, 1'b0,
          st_q.kbc_en, 1'b0, st_q.led_en, st_q.status};
        WDSPC_ADDR_DELAY: st_d.rdata = st_q.delay;
        default: st_d.rdata = WDSPC_RESET_BYTE;
      endcase
    end
    if (st_q.pre == 32'(CYC_SEC - 1)) begin
      st_d.pre = '0;
      st_d.sec_in_min = (st_q.sec_in_min == WDSPC_MIN_LAST) ? '0 : st_q.sec_in_min + 6'h01;
    end else begin
      st_d.pre = st_q.pre + 32'h1;
    end
    if (unit_tick && st_q.value != WDSPC_RESET_BYTE && !st_q.status) begin
      if (st_q.count <= 8'h01) begin
        st_d.count = '0;
        st_d.status = 1'b1;
      end else begin
        st_d.count = st_q.count - 8'h01;
      end
    end
    if (reg_wr) begin
      case (reg_addr)
        WDSPC_ADDR_UNITS: st_d.units = reg_wdata & 8'h80;
        WDSPC_ADDR_VALUE: st_d.value = reg_wdata;
        WDSPC_ADDR_CFG: st_d.cfg = reg_wdata;
        WDSPC_ADDR_DELAY: st_d.delay = reg_wdata;
        WDSPC_ADDR_CTRL: begin
          st_d.status = reg_wdata[WDSPC_CTL_STATUS];
          st_d.led_en = reg_wdata[WDSPC_CTL_LED];
          st_d.kbc_en = reg_wdata[WDSPC_CTL_KBCEN];
        end
        default: st_d.rdata = st_d.rdata;
      endcase
    end
    if (rearm || (reg_wr && reg_addr == WDSPC_ADDR_VALUE)) begin
      st_d.count = (reg_wr && reg_addr == WDSPC_ADDR_VALUE) ? reg_wdata : st_q.value;
      st_d.pre = '0;
      st_d.sec_in_min = '0;
    end
    if (force_ev || (unit_tick && st_q.value != WDSPC_RESET_BYTE && st_q.count <= 8'h01)) begin
      st_d.status = 1'b1;
    end
    if (led_active) begin
      if (st_q.blink_cnt == 32'(CYC_HALF - 1)) begin
        st_d.blink_cnt = '0;
        st_d.blink = !st_q.blink;
      end else begin
        st_d.blink_cnt = st_q.blink_cnt + 32'h1;
      end
    end else begin
      st_d.blink_cnt = '0;
      st_d.blink = 1'b0;
    end
    case (st_q.pb)
      WDSPC_PB_IDLE: begin
        if (btn_s && !st_q.btn_prev) begin
          st_d.pb = WDSPC_PB_RUN;
          st_d.step_left = st_q.delay;
          st_d.step_cnt = '0;
        end
      end
      WDSPC_PB_RUN: begin
        if (st_q.step_cnt == 32'(CYC_STEP - 1)) begin
          st_d.step_cnt = '0;
          if (st_q.step_left <= 8'h01) begin
            st_d.pb = WDSPC_PB_OFF;
          end else begin
            st_d.step_left = st_q.step_left - 8'h01;
          end
        end else begin
          st_d.step_cnt = st_q.step_cnt + 32'h1;
        end
      end
      WDSPC_PB_OFF: begin
        st_d.poff = 1'b1;
        st_d.pb = WDSPC_PB_IDLE;
      end
      default: st_d.pb = WDSPC_PB_IDLE;
    endcase
    if (wr_ctrl) begin
      if (reg_wdata[WDSPC_CTL_RESTART] && st_q.pb == WDSPC_PB_RUN) begin
        st_d.step_left = st_q.delay;
        st_d.step_cnt = '0;
        st_d.pb = WDSPC_PB_RUN;
      end
      if (reg_wdata[WDSPC_CTL_ABORT]) begin
        st_d.pb = WDSPC_PB_IDLE;
      end
      if (reg_wdata[WDSPC_CTL_POFF]) begin
        st_d.pb = WDSPC_PB_OFF;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_q.units <= WDSPC_RESET_BYTE;
      st_q.value <= WDSPC_RESET_BYTE;
      st_q.cfg <= WDSPC_RESET_BYTE;
      st_q.delay <= WDSPC_DELAY_DEFAULT;
      st_q.count <= WDSPC_RESET_BYTE;
      st_q.pre <= '0;
      st_q.sec_in_min <= '0;
      st_q.kbd_prev <= 1'b0;
      st_q.mouse_prev <= 1'b0;
      st_q.kbc_prev <= 1'b0;
      st_q.btn_prev <= 1'b0;
      st_q.rdata <= WDSPC_RESET_BYTE;
      if (!standby_por_n) begin
        st_q.status <= 1'b0;
        st_q.led_en <= 1'b0;
        st_q.kbc_en <= 1'b0;
        st_q.blink_cnt <= '0;
        st_q.blink <= 1'b0;
        st_q.pb <= WDSPC_PB_IDLE;
        st_q.step_left <= '0;
        st_q.step_cnt <= '0;
        st_q.poff <= 1'b0;
      end
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  generate
    for (genvar i = 0; i < 16; i++) begin : g_irq
      assign isa_irq[i] = st_q.status && (st_q.cfg[7:WDSPC_CFG_IRQ_LO] == 4'(i)) &&
        (4'(i) != WDSPC_IRQ_OFF) && (4'(i) != WDSPC_IRQ_BAD);
    end
  endgenerate

  assign reg_rdata = st_q.rdata;
  assign power_led = st_q.blink;
  assign power_down = st_q.poff;

  // reserved bit four is the host's duty; bit is ignored here.

  property p_force;
    @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && wr_ctrl && reg_wdata[WDSPC_CTL_FORCE]) |=> st_q.status;
  endproperty
  a_force: assert property (p_force) else $error("force did not set status");

  property p_zero;
    @(posedge sys_clk) disable iff (!reset_n)
      (st_q.value == 8'h00 && !st_q.status && !force_ev && !(reg_wr && reg_addr == WDSPC_ADDR_CTRL))
      |=> !st_q.status;
  endproperty
  a_zero: assert property (p_zero) else $error("timeout with zero value");

  property p_irq;
    @(posedge sys_clk) disable iff (!reset_n)
      !st_q.status |-> isa_irq == 16'h0000;
  endproperty
  a_irq: assert property (p_irq) else $error("irq without status");

  property p_bad;
    @(posedge sys_clk) disable iff (!reset_n)
      !isa_irq[2] && !isa_irq[0];
  endproperty
  a_bad: assert property (p_bad) else $error("invalid irq line driven");

  property p_led_off;
    @(posedge sys_clk) disable iff (!reset_n)
      (!led_active && clk_en) |=> !power_led;
  endproperty
  a_led_off: assert property (p_led_off) else $error("led toggled while off");

  property p_poff;
    @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && wr_ctrl && reg_wdata[WDSPC_CTL_POFF]) ##1 clk_en |=> power_down ##1 !power_down;
  endproperty
  a_poff: assert property (p_poff) else $error("power off pulse wrong");

  property p_abort;
    @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && wr_ctrl && reg_wdata[WDSPC_CTL_ABORT] && !reg_wdata[WDSPC_CTL_POFF])
      |=> st_q.pb == WDSPC_PB_IDLE;
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not stop delay");

  property p_load;
    @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && reg_wr && reg_addr == WDSPC_ADDR_VALUE) |=> st_q.count == $past(reg_wdata);
  endproperty
  a_load: assert property (p_load) else $error("count not loaded");

  c_force: cover property (@(posedge sys_clk) disable iff (!reset_n) force_ev);
  c_irq: cover property (@(posedge sys_clk) disable iff (!reset_n) |isa_irq);
  c_poff: cover property (@(posedge sys_clk) disable iff (!reset_n) power_down);
endmodule // wdspc_top

// ==== bench/wdspc_pin_model.sv ====
// Outside event sources: game port, keyboard and mouse interrupts,
// keyboard controller force line and power button.
// Assumes tasks are called from the sys_clk domain; all lines idle low.
`timescale 1ns/100ps
module wdspc_pin_model
  import wdspc_pkg::*;
(
  input wire logic sys_clk,
  output logic game_port_access,
  output logic kbd_irq_pin,
  output logic mouse_irq_pin,
  output logic kbc_force_line,
  output logic power_button
);
  logic [4:0] lvl_q = 5'h00;
  assign {power_button, kbc_force_line, mouse_irq_pin, kbd_irq_pin, game_port_access} = lvl_q;
  task automatic drive(input int sel, input logic val);
    @(posedge sys_clk);
    lvl_q[sel] <= val;
  endtask
  // Game port strobe is one cycle; pins held long enough to synchronise
  task automatic pulse(input int sel);
    drive(sel, 1'b1);
    // force line held over 1 us
    if (sel != 0) repeat (sel == 3 ? 55 : 5) @(posedge sys_clk);
    drive(sel, 1'b0);
  endtask
endmodule // wdspc_pin_model

// ==== bench/tb.sv ====
// Self-checking bench for the watchdog and soft power block.
// Assumes shortened bases: 20 cycles a second, 10 a half second, 5 a delay step.
`timescale 1ns/100ps
module tb
  import wdspc_pkg::*;
;
  localparam logic [7:0] A_UN = WDSPC_ADDR_UNITS;
  localparam logic [7:0] A_VA = WDSPC_ADDR_VALUE;
  localparam logic [7:0] A_CF = WDSPC_ADDR_CFG;
  localparam logic [7:0] A_CT = WDSPC_ADDR_CTRL;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic standby_por_n = 1'b0;
  logic clk_en = 1'b1;
  logic dev_activate = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic game_port_access, kbd_irq_pin, mouse_irq_pin, kbc_force_line, power_button;
  logic [15:0] isa_irq;
  logic power_led, power_down;
  logic led_prev = 1'b0;
  logic [7:0] d;
  int n_fail = 0;
  int compares = 0;
  int n_led = 0;
  int n_pd = 0;
  int cyc = 0;
  logic [7:0] ra [5] = '{8'hf1, 8'hf2, 8'hf3, 8'hb8, 8'h10};
  logic [7:0] rv [5] = '{8'h00, 8'h00, 8'h00, 8'h05, 8'h00};
  logic [7:0] lc [4] = '{8'h00, 8'h00, 8'h08, 8'h08};
  logic [7:0] lt [4] = '{8'h02, 8'h00, 8'h04, 8'h00};
  logic [15:0] ln [4] = '{16'h0004, 16'h0000, 16'h0004, 16'h0000};

  wdspc_top #(.CYC_SEC(20), .CYC_HALF(10), .CYC_STEP(5)) DUT (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .standby_por_n(standby_por_n),
    .dev_activate(dev_activate), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .game_port_access(game_port_access), .kbd_irq_pin(kbd_irq_pin),
    .mouse_irq_pin(mouse_irq_pin), .kbc_force_line(kbc_force_line),
    .power_button(power_button), .isa_irq(isa_irq), .power_led(power_led),
    .power_down(power_down));

  wdspc_pin_model pm (
    .sys_clk(sys_clk), .game_port_access(game_port_access), .kbd_irq_pin(kbd_irq_pin),
    .mouse_irq_pin(mouse_irq_pin), .kbc_force_line(kbc_force_line),
    .power_button(power_button));

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // LED toggles, power-down pulses and hang limit
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    led_prev <= power_led;
    if (power_led !== led_prev) n_led <= n_led + 1;
    if (power_down === 1'b1) n_pd <= n_pd + 1;
    if (cyc == 12000) begin
      n_fail = n_fail + 1;
      print_verdict();
    end
  end

  task automatic w(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= (a == A_CT) ? (v & 8'hef) : v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic r(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp, input string nm);
    r(a);
    chk(nm, {8'h00, exp}, {8'h00, d & m});
  endtask
  task automatic cw(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic arm(input logic [7:0] u, input logic [7:0] c, input logic [7:0] v);
    w(A_UN, u);
    w(A_CF, c);
    w(A_VA, v);
    w(A_CT, 8'h00);
  endtask

  initial begin
    int s;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    standby_por_n <= 1'b1;
    w(8'h10, 8'hff);
    for (int i = 0; i < 5; i++) rc(ra[i], 8'hff, rv[i], "reset value");
    rc(A_CT, 8'hdf, 8'h00, "reset control");
    $display("test reset done");
    arm(8'hff, 8'h00, 8'h03);
    rc(A_UN, 8'hff, 8'h80, "units");
    cw(45);
    rc(A_CT, 8'h01, 8'h00, "status before 3 s");
    cw(20);
    rc(A_CT, 8'h01, 8'h01, "status after 3 s");
    arm(8'h00, 8'h00, 8'h01);
    cw(1100);
    rc(A_CT, 8'h01, 8'h00, "status before 1 min");
    cw(150);
    rc(A_CT, 8'h01, 8'h01, "status after 1 min");
    arm(8'h80, 8'h00, 8'h00);
    cw(300);
    rc(A_CT, 8'h01, 8'h00, "value zero");
    $display("test timeout done");
    for (int i = 0; i < 7; i++) begin
      s = (i == 6) ? 1 : i % 3;
      dev_activate <= (i != 6);
      arm(8'h80, (i < 3 || i == 6) ? 8'(1 << s) : 8'h00, 8'h03);
      repeat (5) begin
        pm.pulse(s);
        cw(30);
      end
      rc(A_CT, 8'h01, (i < 3) ? 8'h00 : 8'h01, "rearm status");
    end
    dev_activate <= 1'b1;
    $display("test rearm done");
    arm(8'h00, 8'h00, 8'hff);
    w(A_CT, 8'h04);
    rc(A_CT, 8'hdf, 8'h01, "force");
    for (int v = 0; v < 16; v++) begin
      w(A_CF, 8'(v << 4));
      #1 chk("irq map", (v == 0 || v == 2) ? 16'h0000 : 16'(1 << v), isa_irq);
    end
    w(A_CT, 8'h00);
    #1 chk("irq cleared", 16'h0000, isa_irq);
    w(A_CT, 8'h08);
    pm.drive(3, 1'b1);
    cw(10);
    rc(A_CT, 8'h0f, 8'h09, "kbc force");
    w(A_CT, 8'h08);
    cw(40);
    rc(A_CT, 8'h0f, 8'h08, "kbc level held");
    pm.drive(3, 1'b0);
    w(A_CT, 8'h00);
    pm.pulse(3);
    cw(10);
    rc(A_CT, 8'h0f, 8'h00, "kbc ignored");
    $display("test force done");
    for (int i = 0; i < 4; i++) begin
      w(A_CF, lc[i]);
      w(A_CT, lt[i]);
      cw(15);
      n_led = 0;
      cw(40);
      chk("led toggles", ln[i], 16'(n_led));
    end
    w(A_CT, 8'h00);
    $display("test led done");
    cw(2);
    n_pd = 0;
    w(A_CT, 8'h80);
    cw(5);
    chk("soft power off", 16'h0001, 16'(n_pd));
    rc(A_CT, 8'h80, 8'h00, "power off bit");
    pm.pulse(4);
    rc(A_CT, 8'h20, 8'h00, "delay running");
    w(A_CT, 8'h20);
    rc(A_CT, 8'h20, 8'h20, "delay stopped");
    cw(50);
    chk("abort", 16'h0001, 16'(n_pd));
    pm.pulse(4);
    repeat (4) begin
      cw(12);
      w(A_CT, 8'h40);
    end
    cw(15);
    chk("restart holds", 16'h0001, 16'(n_pd));
    cw(30);
    chk("delay expiry", 16'h0002, 16'(n_pd));
    w(WDSPC_ADDR_DELAY, 8'h02);
    pm.pulse(4);
    chk("short delay running", 16'h0002, 16'(n_pd));
    cw(15);
    chk("short delay expiry", 16'h0003, 16'(n_pd));
    rc(WDSPC_ADDR_DELAY, 8'hff, 8'h02, "delay readback");
    $display("test power done");
    // Freeze counting with the clock enable
    arm(8'h80, 8'h00, 8'h02);
    @(posedge sys_clk);
    clk_en <= 1'b0;
    cw(60);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    rc(A_CT, 8'h01, 8'h00, "status frozen by enable");
    cw(50);
    rc(A_CT, 8'h01, 8'h01, "status after enable");
    $display("test enable done");
    // Main reset keeps control, standby reset clears it
    w(A_VA, 8'h07);
    w(A_CT, 8'h0b);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    rc(A_VA, 8'hff, 8'h00, "value after reset");
    rc(A_CT, 8'h0f, 8'h0b, "control kept over reset");
    @(posedge sys_clk);
    reset_n <= 1'b0;
    standby_por_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    standby_por_n <= 1'b1;
    rc(A_CT, 8'h2f, 8'h20, "control after standby reset");
    $display("test reset again done");
    print_verdict();
  end
endmodule // tb
